// ### lsi_pkg.sv
// Purpose: constants for the lin sync interrupt gate and test route block
// Assumes: apb slave, 32-bit data, one clock pclk at 10 MHz
// Notes: control word is 16 bits; bits above read as zero
// How it works
// - pulse-width mode: bit 12 high blocks rise irq
// - pulse-width mode: bit 12 low allows rise irq
// - lin mode: bit 12 high enables rise irq
// - lin mode: bit 12 low blocks rise irq
// - bit 11 gates break compare irq
// - bit 10 gates break error irq
// - bit 9 high routes transceiver to test pins
// - bit 9 low connects transceiver to uart
// - control register 16-bit, bits 12:0 read/write, bits 15:13 read zero, resets zero
package lsi_pkg;
	localparam int CTRL_W = 16;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
	localparam logic [CTRL_W-1:0] CTRL_WMASK = 16'h1fff;
	localparam int BIT_RISE_DIS = 12;
	localparam int BIT_CMP_DIS = 11;
	localparam int BIT_ERR_DIS = 10;
	localparam int BIT_TEST = 9;
	localparam int NEV = 3;
	localparam int EV_RISE = 0;
	localparam int EV_CMP = 1;
	localparam int EV_ERR = 2;
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STAT = 12'h004;
	localparam logic [11:0] OFS_CLR = 12'h008;
	localparam logic [11:0] OFS_IEN = 12'h00c;
	localparam logic [11:0] OFS_MODE = 12'h010;
	localparam logic [NEV-1:0] IEN_RESET = 3'h7;
endpackage

// ### lsi_flags.sv
// Purpose: sticky event flags with write-one-to-clear
// Assumes: events are one-cycle pulses synchronous to pclk
// Notes: a set in the clearing cycle wins
`timescale 1ns/100ps
module lsi_flags #(
	parameter int N = 3
) (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, low
	input wire logic [N-1:0] set, // event pulses
	input wire logic [N-1:0] clr, // clear pulses
	output logic [N-1:0] flag // sticky flags
);
	logic [N-1:0] next_flag;
	// refuse a width the per-bit loop cannot serve
	if (N < 1) begin : g_bad_width
		$error("lsi_flags: N must be at least 1");
	end
	////////////////////////////////////////////////////////////////////////
	// per-bit next value; set beats clear so no event is lost
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			always_comb begin
				next_flag[i] = set[i] | (flag[i] & ~clr[i]);
			end
		end
	endgenerate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag <= '0;
		end else begin
			flag <= next_flag;
		end
	end
endmodule

// ### lsi_route.sv
// Purpose: transceiver routing between uart and test pins
// Assumes: test pins already set to their function by software
// Notes: registered so every path adds one pclk of latency
`timescale 1ns/100ps
module lsi_route (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, low
	input wire logic test_mode, // standalone test select
	input wire logic uart_txd, // uart transmit
	input wire logic xcvr_rxd, // transceiver receive
	input wire logic test_pin_in, // first test pin level
	output logic xcvr_txd, // to transceiver transmit
	output logic uart_rxd, // to uart receive
	output logic test_pin_out // to second test pin
);
	logic next_xcvr_txd;
	logic next_uart_rxd;
	logic next_test_pin_out;
	////////////////////////////////////////////////////////////////////////
	// select path; uart rx idles high in test mode to avoid junk bytes
	always_comb begin
		if (test_mode) begin
			next_xcvr_txd = test_pin_in;
			next_test_pin_out = xcvr_rxd;
			next_uart_rxd = 1'b1;
		end else begin
			next_xcvr_txd = uart_txd;
			next_uart_rxd = xcvr_rxd;
			next_test_pin_out = 1'b1;
		end
	end
	// recessive level high out of reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xcvr_txd <= 1'b1;
			uart_rxd <= 1'b1;
			test_pin_out <= 1'b1;
		end else begin
			xcvr_txd <= next_xcvr_txd;
			uart_rxd <= next_uart_rxd;
			test_pin_out <= next_test_pin_out;
		end
	end
endmodule

// ### lsi_top.sv
// Purpose: lin sync control word, interrupt gating and test routing
// Assumes: apb3 slave, zero wait states, events synchronous to pclk
// Notes: mode select is a register of its own at OFS_MODE
`timescale 1ns/100ps
module lsi_top
	import lsi_pkg::*;
(
	input wire logic pclk, // clock, 10 MHz
	input wire logic presetn, // async reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic ev_rise, // rising edge detected pulse
	input wire logic ev_cmp, // break compare pulse
	input wire logic ev_err, // break error pulse
	input wire logic uart_txd, // uart transmit
	input wire logic xcvr_rxd, // transceiver receive
	input wire logic test_pin_in, // first test pin
	output logic xcvr_txd, // transceiver transmit
	output logic uart_rxd, // uart receive
	output logic test_pin_out, // second test pin
	output logic [NEV-1:0] irq_req, // gated requests
	output logic irq // level interrupt
);
	logic [CTRL_W-1:0] ctrl;
	logic [CTRL_W-1:0] next_ctrl;
	logic [NEV-1:0] ien;
	logic [NEV-1:0] next_ien;
	logic mode_pwb;
	logic next_mode_pwb;
	logic [NEV-1:0] clr;
	logic [NEV-1:0] flag;
	logic [NEV-1:0] gate;
	logic [NEV-1:0] next_req;
	logic next_irq;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic acc;
	logic hit;
	////////////////////////////////////////////////////////////////////////
	// apb: answer in setup, ready held high, so zero wait states
	assign acc = psel & penable;
	always_comb begin
		next_ctrl = ctrl;
		next_ien = ien;
		next_mode_pwb = mode_pwb;
		clr = '0;
		hit = 1'b1;
		next_prdata = '0;
		case (paddr)
			OFS_CTRL: next_prdata = {16'h0000, ctrl};
			OFS_STAT: next_prdata = {29'h0, flag};
			OFS_CLR: next_prdata = '0;
			OFS_IEN: next_prdata = {29'h0, ien};
			OFS_MODE: next_prdata = {31'h0, mode_pwb};
			default: hit = 1'b0;
		endcase
		if (acc && pwrite && hit) begin
			case (paddr)
				OFS_CTRL: next_ctrl = pwdata[CTRL_W-1:0] & CTRL_WMASK;
				OFS_CLR: clr = pwdata[NEV-1:0];
				OFS_IEN: next_ien = pwdata[NEV-1:0];
				OFS_MODE: next_mode_pwb = pwdata[0];
				default: clr = '0;
			endcase
		end
		if (!(psel && !penable && !pwrite)) begin
			next_prdata = prdata;
		end
		next_pslverr = psel && !penable && !hit;
		if (acc) begin
			next_pslverr = pslverr;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// per-source disable decode; bit 12 polarity flips with mode
	always_comb begin
		if (mode_pwb) begin
			gate[EV_RISE] = ~ctrl[BIT_RISE_DIS];
		end else begin
			gate[EV_RISE] = ctrl[BIT_RISE_DIS];
		end
		gate[EV_CMP] = ~ctrl[BIT_CMP_DIS];
		gate[EV_ERR] = ~ctrl[BIT_ERR_DIS];
		// flags set regardless; only the request is masked
		next_req = flag & gate;
		next_irq = |(next_req & ien);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET;
			ien <= IEN_RESET;
			mode_pwb <= 1'b0;
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq_req <= '0;
			irq <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			ien <= next_ien;
			mode_pwb <= next_mode_pwb;
			prdata <= next_prdata;
			pready <= 1'b1;
			pslverr <= next_pslverr;
			irq_req <= next_req;
			irq <= next_irq;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// sticky flags see every event even when its request is disabled
	lsi_flags #(
		.N(NEV)
	) u_flags (
		.pclk(pclk),
		.presetn(presetn),
		.set({ev_err, ev_cmp, ev_rise}),
		.clr(clr),
		.flag(flag)
	);
	// software must pick pin functions before raising bit 9
	lsi_route u_route (
		.pclk(pclk),
		.presetn(presetn),
		.test_mode(ctrl[BIT_TEST]),
		.uart_txd(uart_txd),
		.xcvr_rxd(xcvr_rxd),
		.test_pin_in(test_pin_in),
		.xcvr_txd(xcvr_txd),
		.uart_rxd(uart_rxd),
		.test_pin_out(test_pin_out)
	);
endmodule

// ### lsi_xcvr_model.sv
// Purpose: transceiver model, echoes transmit onto receive
// Assumes: recessive high bus
// Notes: one pclk echo delay
`timescale 1ns/100ps
module lsi_xcvr_model (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, low
	input wire logic xcvr_txd, // from device
	output logic xcvr_rxd // bus level
);
	// echo; bus floats recessive in reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) xcvr_rxd <= 1'b1;
		else xcvr_rxd <= xcvr_txd;
	end
endmodule

// ### lsi_top_assertions.sv
// Purpose: port checks for lsi_top
// Assumes: control mirrored from apb writes
// Notes: bound below
`timescale 1ns/100ps
module lsi_top_assertions
	import lsi_pkg::*;
(
	input wire logic pclk, // clock
	input wire logic presetn, // reset
	input wire logic psel, // select
	input wire logic penable, // access
	input wire logic pwrite, // write
	input wire logic [11:0] paddr, // address
	input wire logic [31:0] pwdata, // wdata
	input wire logic [31:0] prdata, // rdata
	input wire logic pready, // ready
	input wire logic ev_rise, // event
	input wire logic uart_txd, // in
	input wire logic xcvr_rxd, // in
	input wire logic test_pin_in, // in
	input wire logic xcvr_txd, // out
	input wire logic uart_rxd, // out
	input wire logic test_pin_out, // out
	input wire logic [NEV-1:0] irq_req, // out
	input wire logic irq // out
);
	logic [15:0] ctl;
	logic pwm;
	logic wr;
	logic ren;
	logic [NEV-1:0] ien_mirror;
	assign wr = psel && penable && pwrite && pready;
	assign ren = pwm ? !ctl[12] : ctl[12];
	// mirror taken at the write edge, as the design does
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl <= CTRL_RESET;
			pwm <= 1'b0;
			ien_mirror <= IEN_RESET;
		end else if (wr && paddr == OFS_CTRL) begin
			ctl <= pwdata[15:0] & CTRL_WMASK;
		end else if (wr && paddr == OFS_MODE) begin
			pwm <= pwdata[0];
		end else if (wr && paddr == OFS_IEN) begin
			ien_mirror <= pwdata[NEV-1:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_rise_gate: assert property (irq_req[0] |-> $past(ren))
		else $error("rise gate");
	a_rise_fire: assert property (ev_rise && ren ##1 ren |=> irq_req[0])
		else $error("rise fire");
	a_cmp_gate: assert property (irq_req[1] |-> !$past(ctl[11]))
		else $error("cmp gate");
	a_err_gate: assert property (irq_req[2] |-> !$past(ctl[10]))
		else $error("err gate");
	a_tx_route: assert property (xcvr_txd == $past(ctl[9] ? test_pin_in : uart_txd))
		else $error("tx route");
	a_rx_route: assert property (uart_rxd == $past(ctl[9] | xcvr_rxd))
		else $error("rx route");
	a_pin_route: assert property (test_pin_out == $past(!ctl[9] | xcvr_rxd))
		else $error("pin route");
	// level follows gated requests through the enable mask
	a_irq_level: assert property (irq == |(irq_req & $past(ien_mirror)))
		else $error("irq level");
	a_ctrl_read: assert property (psel && penable && !pwrite
		&& paddr == OFS_CTRL |-> prdata == {16'h0000, ctl})
		else $error("ctrl read");
	c_irq: cover property (irq);
	c_test: cover property (ctl[9] && !test_pin_out);
	c_rise: cover property (ev_rise && ren);
endmodule
bind lsi_top lsi_top_assertions lsi_top_assertions_i (.*);

// ### lsi_top_tb.sv
// Purpose: self-checking bench for lsi_top
// Assumes: echoing transceiver model
// Notes: apb waits on pready, bounded
`timescale 1ns/100ps
module lsi_top_tb
	import lsi_pkg::*;
();
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdv;
	logic pready, pslverr, serr, xcvr_txd, uart_rxd, test_pin_out, irq;
	logic xcvr_rxd, ev_rise = 0, ev_cmp = 0, ev_err = 0;
	logic uart_txd = 1, test_pin_in = 1;
	logic [NEV-1:0] irq_req;
	int err_total = 0, checks_done = 0, cyc = 0;
	lsi_top lsi_top_i (.*);
	lsi_xcvr_model lsi_xcvr_model_i (.*);
	initial forever #50 pclk = ~pclk;
	// cut a hang short
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			test_done();
		end
	end
	task automatic test_done();
		if (err_total == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("[ERR] %s exp %h got %h", nm, e, g);
			err_total++;
		end
	endtask
	// one transfer; outputs read before the edge's updates land
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdv = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulse(logic [2:0] b);
		@(posedge pclk);
		{ev_err, ev_cmp, ev_rise} <= b;
		@(posedge pclk);
		{ev_err, ev_cmp, ev_rise} <= 3'h0;
		repeat (3) @(posedge pclk);
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, OFS_CTRL, 0);
		chk("ctrl", 32'h0, rdv);
		apb(0, OFS_IEN, 0);
		chk("ien", 32'h7, rdv);
		apb(0, OFS_MODE, 0);
		chk("mode", 32'h0, rdv);
		apb(1, OFS_CTRL, 32'hffff_ffff);
		apb(0, OFS_CTRL, 0);
		chk("ctrl", 32'h1fff, rdv);
		apb(0, 12'h020, 0);
		chk("slverr", 1, serr);
		for (int m = 0; m < 2; m++) begin
			for (int b = 0; b < 2; b++) begin
				apb(1, OFS_MODE, m);
				apb(1, OFS_CTRL, b << 12);
				pulse(3'h1);
				chk("rise", m ? !b : b, irq_req[0]);
				apb(0, OFS_STAT, 0);
				chk("stat", 1, rdv);
				apb(1, OFS_CLR, 7);
			end
		end
		for (int i = 0; i < 4; i++) begin
			apb(1, OFS_CTRL, i << 10);
			pulse(3'h6);
			chk("cmp_err", {~i[0], ~i[1]}, irq_req[2:1]);
			apb(1, OFS_CLR, 7);
		end
		// mask hides the level only
		apb(1, OFS_IEN, 0);
		apb(1, OFS_CTRL, 0);
		pulse(3'h1);
		chk("masked", 2'b01, {irq, irq_req[0]});
		apb(1, OFS_IEN, 7);
		repeat (2) @(posedge pclk);
		chk("irq", 1, irq);
		apb(1, OFS_CLR, 7);
		repeat (2) @(posedge pclk);
		chk("irq", 0, irq);
		uart_txd <= 1'b0;
		repeat (4) @(posedge pclk);
		chk("uart", 2'b01, {uart_rxd, test_pin_out});
		// test pins already idle at their function before bit 9 rises
		apb(1, OFS_CTRL, 32'h200);
		uart_txd <= 1'b1;
		test_pin_in <= 1'b0;
		repeat (4) @(posedge pclk);
		chk("test", 2'b10, {uart_rxd, test_pin_out});
		// mid-run reset must bring the control word back to zero
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, OFS_CTRL, 0);
		chk("ctrl_rst", 32'h0, rdv);
		chk("route_rst", 2'b11, {uart_rxd, test_pin_out});
		test_done();
	end
endmodule
